//--- hw/dcf_consts.svh
// register offsets, field positions, reset values of the debug comparator block
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCF_IDX_CA_HI    4'h0
`define DCF_IDX_CA_LO    4'h1
`define DCF_IDX_CB_HI    4'h2
`define DCF_IDX_CB_LO    4'h3
`define DCF_IDX_CC_HI    4'h4
`define DCF_IDX_CC_LO    4'h5
`define DCF_IDX_FIFO_HI  4'h6
`define DCF_IDX_FIFO_LO  4'h7
`define DCF_IDX_CA_EXT   4'h8
`define DCF_IDX_FIFO_EXT 4'hb
`define DCF_IDX_CTRL     4'hc
`define DCF_IDX_STATUS   4'he

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCF_RST_CA_HI    8'hff
`define DCF_RST_CA_LO    8'hfe
`define DCF_RST_ZERO     8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCF_EXT_DIR_EN   7
`define DCF_EXT_DIR_VAL  6
`define DCF_EXT_PAGE     5
`define DCF_EXT_BIT16    0
`define DCF_EXT_MASK     8'he1
`define DCF_FX_PAGED     7
`define DCF_CTRL_EN      7
`define DCF_CTRL_BEGIN   6
`define DCF_CTRL_FULL    1
`define DCF_CTRL_EVONLY  0
`define DCF_STAT_ARMED   0
`define DCF_STAT_AM      1
`define DCF_STAT_BM      2
`define DCF_STAT_CM      3
`define DCF_STAT_EMPTY   4

// ----------------------------------------------------------------
// fifo geometry and bus answers
// ----------------------------------------------------------------
`define DCF_FIFO_DEPTH   8
`define DCF_FIFO_AW      3
`define DCF_RESP_OKAY    2'h0
`define DCF_RESP_SLVERR  2'h2

`endif

//--- hw/dcf_pkg.sv
// types shared by the debug comparator block
package dcf_pkg;
    typedef enum logic [1:0] {
        DCF_AXI_IDLE,
        DCF_AXI_RESP
    } dcf_axi_state_t;

    typedef struct packed {
        logic        paged;
        logic [15:0] word;
    } dcf_trace_word_t;
endpackage

//--- hw/dcf_cmp_if.sv
// bundle between the register block and one address comparator
`timescale 1ns/1ps
`default_nettype none
interface dcf_cmp_if;
    logic [15:0] value;
    logic [7:0]  ext;
    logic        use_hi;
    logic        use_ext;
    logic        match;
    modport regs (output value, ext, use_hi, use_ext, input match);
    modport cmp  (input value, ext, use_hi, use_ext, output match);
endinterface
`default_nettype wire

//--- hw/dcf_comparator.sv
// one bitwise comparator with optional direction, page and bit-16 terms
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_comparator
    import dcf_pkg::*;
(
    // clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // observed bus cycle
    input  wire logic [16:0] addr,
    input  wire logic  paged,
    input  wire logic  read_cycle,
    input  wire logic  cycle_valid,
    // settings and result
    dcf_cmp_if.cmp     cfg
);
    logic hi_ok;
    logic lo_ok;
    logic dir_ok;
    logic page_ok;
    logic b16_ok;

    // bitwise equality, stored 1 matches 1
    assign hi_ok = !cfg.use_hi || (addr[15:8] == cfg.value[15:8]);
    assign lo_ok = addr[7:0] == cfg.value[7:0];
    // direction only when qualifier enabled, 1 = read
    assign dir_ok = !cfg.use_ext || !cfg.ext[`DCF_EXT_DIR_EN] ||
                    (read_cycle == cfg.ext[`DCF_EXT_DIR_VAL]);
    // page select must agree with paged-access flag
    assign page_ok = !cfg.use_ext || (paged == cfg.ext[`DCF_EXT_PAGE]);
    assign b16_ok  = !cfg.use_ext || (addr[16] == cfg.ext[`DCF_EXT_BIT16]);

    // all qualifiers agree in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg.match <= 1'b0;
        end else begin
            cfg.match <= cycle_valid && hi_ok && lo_ok && dir_ok &&
                         page_ok && b16_ok;
        end
    end
endmodule
`default_nettype wire

//--- hw/dcf_top.sv
// debug comparator and trace fifo register block with axi4-lite slave
//
// Behaviour
// - comparator a matches address bits bitwise
// - full mode ignores comparator b high byte
// - comparator b low byte matches data in full
// - comparator c matches address bits bitwise
// - fifo high byte reads word bits 15..8, zero in event-only mode
// - reading fifo low byte advances fifo
// - bit 7 enables direction qualifier
// - bit 6 picks read or write cycles
// - page select 1 matches paged accesses only
// - page select 0 matches unpaged accesses only
// - extension bit 0 is expected address bit 16
// - end-run reset keeps comparator and fifo values while enabled with begin-trace clear
// - enable forced low while part is secured
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_top
    import dcf_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // axi4-lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // core bus observation, same clock
    input  wire logic [16:0] core_addr,
    input  wire logic [7:0]  core_data,
    input  wire logic        core_paged,
    input  wire logic        core_read,
    input  wire logic        core_valid,
    // system state, same clock
    input  wire logic        secured,
    input  wire logic        end_run_reset,
    // trace capture feed
    input  wire logic        capture_valid,
    input  wire logic [16:0] capture_word,
    // comparator results
    output var  logic        match_a,
    output var  logic        match_b,
    output var  logic        match_c
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]  comp_a_high_byte;
    logic [7:0]  comp_a_low_byte;
    logic [7:0]  comp_b_high_byte;
    logic [7:0]  comp_b_low_byte;
    logic [7:0]  comp_c_high_byte;
    logic [7:0]  comp_c_low_byte;
    logic [7:0]  comp_a_extension;
    logic        module_enable;
    logic        begin_trace;
    logic        full_mode;
    logic        event_only;
    logic        keep;
    dcf_trace_word_t fifo_mem [`DCF_FIFO_DEPTH];
    logic [`DCF_FIFO_AW-1:0] rd_ptr;
    logic [`DCF_FIFO_AW-1:0] wr_ptr;
    logic [`DCF_FIFO_AW:0]   fifo_count;
    dcf_trace_word_t         head;
    logic [7:0]  trace_fifo_high_byte;
    logic [7:0]  trace_fifo_low_byte;
    logic [7:0]  trace_fifo_extension;

    // ----------------------------------------------------------------
    // bus slave state
    // ----------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_idx;
    logic [31:0] w_data;
    logic        w_all;
    logic        do_write;
    logic        do_read;
    logic [3:0]  ar_idx;
    logic        pop;
    logic        push;
    logic [31:0] next_rdata;
    logic        rd_ok;
    logic        wr_ok;

    // end-run reset while enabled with begin-trace clear keeps state, any other reset loads defaults
    assign keep = end_run_reset && module_enable && !begin_trace;

    // ----------------------------------------------------------------
    // axi write path: address and data taken in either order
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                      (w_held || (s_axi_wvalid && s_axi_wready)) &&
                      !s_axi_bvalid;

    // hold write address and data until both are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_all   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_all  <= s_axi_wstrb[0];
            end
            aw_held <= do_write ? 1'b0 :
                       (aw_held || (s_axi_awvalid && s_axi_awready));
            w_held  <= do_write ? 1'b0 :
                       (w_held || (s_axi_wvalid && s_axi_wready));
        end
    end

    logic [3:0] wr_idx;
    logic [7:0] wr_byte;
    logic       wr_lane;
    assign wr_idx  = aw_held ? aw_idx : s_axi_awaddr[5:2];
    assign wr_byte = w_held ? w_data[7:0] : s_axi_wdata[7:0];
    assign wr_lane = w_held ? w_all : s_axi_wstrb[0];

    // write response decode, fifo and status writes answer okay but change nothing
    always_comb begin
        case (wr_idx)
            `DCF_IDX_CA_HI, `DCF_IDX_CA_LO, `DCF_IDX_CB_HI,
            `DCF_IDX_CB_LO, `DCF_IDX_CC_HI, `DCF_IDX_CC_LO,
            `DCF_IDX_CA_EXT, `DCF_IDX_CTRL,
            `DCF_IDX_FIFO_HI, `DCF_IDX_FIFO_LO,
            `DCF_IDX_FIFO_EXT, `DCF_IDX_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DCF_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // comparator and control registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (!keep) begin
                comp_a_high_byte <= `DCF_RST_CA_HI;
                comp_a_low_byte  <= `DCF_RST_CA_LO;
                comp_b_high_byte <= `DCF_RST_ZERO;
                comp_b_low_byte  <= `DCF_RST_ZERO;
                comp_c_high_byte <= `DCF_RST_ZERO;
                comp_c_low_byte  <= `DCF_RST_ZERO;
                comp_a_extension <= `DCF_RST_ZERO;
            end
        end else if (do_write && wr_lane) begin
            case (wr_idx)
                `DCF_IDX_CA_HI:  comp_a_high_byte <= wr_byte;
                `DCF_IDX_CA_LO:  comp_a_low_byte  <= wr_byte;
                `DCF_IDX_CB_HI:  comp_b_high_byte <= wr_byte;
                `DCF_IDX_CB_LO:  comp_b_low_byte  <= wr_byte;
                `DCF_IDX_CC_HI:  comp_c_high_byte <= wr_byte;
                `DCF_IDX_CC_LO:  comp_c_low_byte  <= wr_byte;
                `DCF_IDX_CA_EXT:
                    comp_a_extension <= wr_byte & `DCF_EXT_MASK;
                default: ;
            endcase
        end
    end

    // control: enable, begin-trace, full and event-only modes
    always_ff @(posedge aclk) begin
        if (!aresetn && !keep) begin
            module_enable <= 1'b0;
            begin_trace   <= 1'b1;
            full_mode     <= 1'b0;
            event_only    <= 1'b0;
        end else if (secured) begin
            module_enable <= 1'b0;
        end else if (aresetn && do_write && wr_lane &&
                     wr_idx == `DCF_IDX_CTRL) begin
            module_enable <= wr_byte[`DCF_CTRL_EN];
            begin_trace   <= wr_byte[`DCF_CTRL_BEGIN];
            full_mode     <= wr_byte[`DCF_CTRL_FULL];
            event_only    <= wr_byte[`DCF_CTRL_EVONLY];
        end
    end

    // ----------------------------------------------------------------
    // trace fifo
    // ----------------------------------------------------------------
    assign head = fifo_mem[rd_ptr];
    assign push = aresetn && module_enable && capture_valid &&
                  fifo_count != (`DCF_FIFO_AW+1)'(`DCF_FIFO_DEPTH);
    assign pop  = do_read && ar_idx == `DCF_IDX_FIFO_LO &&
                  fifo_count != '0;

    // storage, written by the capture feed
    always_ff @(posedge aclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= '{paged: capture_word[16],
                                  word:  capture_word[15:0]};
        end
    end

    // pointers advance on capture and on low-byte reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (!keep) begin
                rd_ptr     <= '0;
                wr_ptr     <= '0;
                fifo_count <= '0;
            end
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fifo_count <= fifo_count + (`DCF_FIFO_AW+1)'(push) -
                          (`DCF_FIFO_AW+1)'(pop);
        end
    end

    // event-only words carry nothing in high byte or extension
    assign trace_fifo_high_byte = (fifo_count == '0 || event_only) ?
                                  8'h00 : head.word[15:8];
    assign trace_fifo_low_byte  = (fifo_count == '0) ?
                                  8'h00 : head.word[7:0];
    assign trace_fifo_extension = {(fifo_count != '0) && !event_only &&
                                   head.paged, 7'h00};

    // ----------------------------------------------------------------
    // axi read path
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign ar_idx  = s_axi_araddr[5:2];

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok      = 1'b1;
        case (ar_idx)
            `DCF_IDX_CA_HI:    next_rdata[7:0] = comp_a_high_byte;
            `DCF_IDX_CA_LO:    next_rdata[7:0] = comp_a_low_byte;
            `DCF_IDX_CB_HI:    next_rdata[7:0] = comp_b_high_byte;
            `DCF_IDX_CB_LO:    next_rdata[7:0] = comp_b_low_byte;
            `DCF_IDX_CC_HI:    next_rdata[7:0] = comp_c_high_byte;
            `DCF_IDX_CC_LO:    next_rdata[7:0] = comp_c_low_byte;
            `DCF_IDX_FIFO_HI:  next_rdata[7:0] = trace_fifo_high_byte;
            `DCF_IDX_FIFO_LO:  next_rdata[7:0] = trace_fifo_low_byte;
            `DCF_IDX_CA_EXT:   next_rdata[7:0] = comp_a_extension;
            `DCF_IDX_FIFO_EXT: next_rdata[7:0] = trace_fifo_extension;
            `DCF_IDX_CTRL: begin
                next_rdata[`DCF_CTRL_EN]     = module_enable;
                next_rdata[`DCF_CTRL_BEGIN]  = begin_trace;
                next_rdata[`DCF_CTRL_FULL]   = full_mode;
                next_rdata[`DCF_CTRL_EVONLY] = event_only;
            end
            `DCF_IDX_STATUS: begin
                next_rdata[`DCF_STAT_ARMED] = module_enable;
                next_rdata[`DCF_STAT_AM]    = match_a;
                next_rdata[`DCF_STAT_BM]    = match_b;
                next_rdata[`DCF_STAT_CM]    = match_c;
                next_rdata[`DCF_STAT_EMPTY] = fifo_count == '0;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DCF_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_ok ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // comparators
    // ----------------------------------------------------------------
    dcf_cmp_if cmp_a ();
    dcf_cmp_if cmp_b ();
    dcf_cmp_if cmp_c ();
    logic [16:0] b_subject;
    logic        cyc;

    assign cyc = core_valid && module_enable;
    // comparator a: address plus extension qualifiers
    assign cmp_a.value   = {comp_a_high_byte, comp_a_low_byte};
    assign cmp_a.ext     = comp_a_extension;
    assign cmp_a.use_hi  = 1'b1;
    assign cmp_a.use_ext = 1'b1;
    // comparator b: data byte in full mode, high byte unused
    assign cmp_b.value   = {comp_b_high_byte, comp_b_low_byte};
    assign cmp_b.ext     = 8'h00;
    assign cmp_b.use_hi  = !full_mode;
    assign cmp_b.use_ext = 1'b0;
    assign b_subject = full_mode ? {9'h000, core_data} : core_addr;
    // comparator c: plain address
    assign cmp_c.value   = {comp_c_high_byte, comp_c_low_byte};
    assign cmp_c.ext     = 8'h00;
    assign cmp_c.use_hi  = 1'b1;
    assign cmp_c.use_ext = 1'b0;

    dcf_comparator u_cmp_a (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .addr        (core_addr),
        .paged       (core_paged),
        .read_cycle  (core_read),
        .cycle_valid (cyc),
        .cfg         (cmp_a.cmp)
    );
    dcf_comparator u_cmp_b (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .addr        (b_subject),
        .paged       (core_paged),
        .read_cycle  (core_read),
        .cycle_valid (cyc),
        .cfg         (cmp_b.cmp)
    );
    dcf_comparator u_cmp_c (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .addr        (core_addr),
        .paged       (core_paged),
        .read_cycle  (core_read),
        .cycle_valid (cyc),
        .cfg         (cmp_c.cmp)
    );

    // registered match outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a <= 1'b0;
            match_b <= 1'b0;
            match_c <= 1'b0;
        end else begin
            match_a <= cmp_a.match;
            match_b <= cmp_b.match;
            match_c <= cmp_c.match;
        end
    end
endmodule
`default_nettype wire

//--- dv/dcf_top_sva.sv
// port-level checks for the debug comparator block
`timescale 1ns/1ps
`default_nettype none
module dcf_top_sva (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // core bus and results
    input wire logic        core_valid,
    input wire logic        secured,
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        match_c
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
        else $error("no write response after write");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read data after read address");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    match_cause_a: assert property (match_a |-> $past(core_valid, 2))
        else $error("match a without bus cycle");
    bc_cause_a: assert property (match_b || match_c |-> $past(core_valid, 2))
        else $error("match b or c without bus cycle");
    secured_quiet_a: assert property (secured [*5]
        |-> !(match_a || match_b || match_c))
        else $error("match while secured");
endmodule
bind dcf_top dcf_top_sva u_sva (.*);
`default_nettype wire

//--- dv/dcf_core_model.sv
// core bus and trace feed model
`timescale 1ns/1ps
`default_nettype none
module dcf_core_model (
    // clock
    input  wire logic        aclk,
    // core bus
    output var  logic [16:0] core_addr,
    output var  logic [7:0]  core_data,
    output var  logic        core_paged,
    output var  logic        core_read,
    output var  logic        core_valid,
    // trace feed
    output var  logic        capture_valid,
    output var  logic [16:0] capture_word
);
    // idle bus at time zero
    initial begin
        {core_addr, core_data, core_paged, core_read} = 27'h0;
        {core_valid, capture_valid, capture_word} = 19'h0;
    end
    // one bus cycle, then stale lines show junk
    task automatic bus(input logic [16:0] a, input logic [7:0] d,
                       input logic p, input logic r);
        @(posedge aclk);
        core_addr <= a;
        core_data <= d;
        core_paged <= p;
        core_read <= r;
        core_valid <= 1'b1;
        @(posedge aclk);
        core_valid <= 1'b0;
        core_addr <= ~a;
        core_data <= ~d;
    endtask
    // one trace word push
    task automatic push(input logic [16:0] w);
        @(posedge aclk);
        capture_valid <= 1'b1;
        capture_word <= w;
        @(posedge aclk);
        capture_valid <= 1'b0;
        capture_word <= ~w;
    endtask
endmodule
`default_nettype wire

//--- dv/dcf_top_test.sv
// self-checking bench for the debug comparator block
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module dcf_top_test
    import dcf_pkg::*;
;
    logic        aclk, aresetn, secured, end_run_reset;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, core_paged, core_read;
    logic [16:0] core_addr, capture_word;
    logic [7:0]  core_data;
    logic        core_valid, capture_valid, match_a, match_b, match_c;
    int          err_total, comparisons;
    dcf_top dut (.*);
    dcf_core_model core (.*);
    // clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // register write, address and data offered together
    task automatic wr(input logic [3:0] i, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // register read
    task automatic rd(input logic [3:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // read and compare one byte register
    task automatic rc(input logic [3:0] i, input logic [7:0] e);
        rd(i);
        `CHK(d, {24'h0, e});
        `CHK(r, `DCF_RESP_OKAY);
    endtask
    // one core cycle, then collect the three match outputs
    task automatic cyc(input logic [16:0] a, input logic [7:0] v,
                       input logic p, input logic rw, input logic [2:0] e);
        logic [2:0] h;
        h = 3'b000;
        core.bus(a, v, p, rw);
        repeat (4) begin
            @(posedge aclk);
            #1;
            h = h | {match_a, match_b, match_c};
        end
        `CHK(h, e);
    endtask
    // synchronous reset, optionally marked as end of a trace run
    task automatic rst(input logic e);
        @(posedge aclk);
        end_run_reset <= e;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        end_run_reset <= 1'b0;
    endtask
    // verdict
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        stop_test;
    end
    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready, secured} = 3'b000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
        s_axi_wstrb = 4'h1;
        {aresetn, end_run_reset} = 2'b00;
        err_total = 0;
        comparisons = 0;
        rst(1'b0);
        rc(`DCF_IDX_CA_HI, `DCF_RST_CA_HI);
        rc(`DCF_IDX_CA_LO, `DCF_RST_CA_LO);
        for (int i = 2; i < 9; i++) rc(i[3:0], `DCF_RST_ZERO);
        rd(4'h9);
        `CHK(r, `DCF_RESP_SLVERR);
        wr(4'h9, 8'h00);
        `CHK(r, `DCF_RESP_SLVERR);
        wr(`DCF_IDX_CA_EXT, 8'hff);
        rc(`DCF_IDX_CA_EXT, `DCF_EXT_MASK);
        wr(`DCF_IDX_CTRL, 8'h80);
        wr(`DCF_IDX_CA_HI, 8'h12);
        wr(`DCF_IDX_CA_LO, 8'h34);
        wr(`DCF_IDX_CA_EXT, 8'h00);
        cyc(17'h01234, 8'h00, 1'b0, 1'b0, 3'b100);
        cyc(17'h01235, 8'h00, 1'b0, 1'b0, 3'b000);
        cyc(17'h01334, 8'h00, 1'b0, 1'b0, 3'b000);
        cyc(17'h11234, 8'h00, 1'b0, 1'b0, 3'b000);
        cyc(17'h01234, 8'h00, 1'b1, 1'b0, 3'b000);
        wr(`DCF_IDX_CA_EXT, 8'hc0);
        cyc(17'h01234, 8'h00, 1'b0, 1'b0, 3'b000);
        cyc(17'h01234, 8'h00, 1'b0, 1'b1, 3'b100);
        wr(`DCF_IDX_CA_EXT, 8'h40);
        cyc(17'h01234, 8'h00, 1'b0, 1'b0, 3'b100);
        wr(`DCF_IDX_CA_EXT, 8'he1);
        cyc(17'h11234, 8'h00, 1'b1, 1'b1, 3'b100);
        cyc(17'h11234, 8'h00, 1'b1, 1'b0, 3'b000);
        cyc(17'h11234, 8'h00, 1'b0, 1'b1, 3'b000);
        wr(`DCF_IDX_CB_HI, 8'h56);
        wr(`DCF_IDX_CB_LO, 8'h78);
        cyc(17'h05678, 8'h00, 1'b0, 1'b1, 3'b010);
        wr(`DCF_IDX_CTRL, 8'h82);
        cyc(17'h05678, 8'h00, 1'b0, 1'b1, 3'b000);
        cyc(17'h0ff78, 8'h78, 1'b0, 1'b1, 3'b010);
        wr(`DCF_IDX_CTRL, 8'h80);
        wr(`DCF_IDX_CC_HI, 8'h9a);
        wr(`DCF_IDX_CC_LO, 8'hbc);
        cyc(17'h09abc, 8'h00, 1'b0, 1'b0, 3'b001);
        cyc(17'h09a3c, 8'h00, 1'b0, 1'b0, 3'b000);
        core.push(17'h1a55c);
        core.push(17'h00312);
        wr(`DCF_IDX_FIFO_HI, 8'h77);
        `CHK(r, `DCF_RESP_OKAY);
        rc(`DCF_IDX_FIFO_EXT, 8'h80);
        rc(`DCF_IDX_FIFO_HI, 8'ha5);
        rc(`DCF_IDX_FIFO_HI, 8'ha5);
        rc(`DCF_IDX_FIFO_LO, 8'h5c);
        rc(`DCF_IDX_FIFO_EXT, 8'h00);
        rc(`DCF_IDX_FIFO_HI, 8'h03);
        rc(`DCF_IDX_FIFO_LO, 8'h12);
        rc(`DCF_IDX_FIFO_LO, 8'h00);
        wr(`DCF_IDX_CTRL, 8'h81);
        core.push(17'h0beef);
        rc(`DCF_IDX_FIFO_HI, 8'h00);
        rc(`DCF_IDX_FIFO_LO, 8'hef);
        rst(1'b1);
        rc(`DCF_IDX_CA_HI, 8'h12);
        rst(1'b0);
        rc(`DCF_IDX_CA_HI, `DCF_RST_CA_HI);
        @(posedge aclk);
        secured <= 1'b1;
        wr(`DCF_IDX_CTRL, 8'h80);
        rc(`DCF_IDX_CTRL, 8'h40);
        cyc(17'h0fffe, 8'h00, 1'b0, 1'b0, 3'b000);
        @(posedge aclk);
        secured <= 1'b0;
        wr(`DCF_IDX_CTRL, 8'h80);
        cyc(17'h0fffe, 8'h00, 1'b0, 1'b0, 3'b100);
        stop_test;
    end
endmodule
`default_nettype wire
